// ### rtl/nid_pkg.sv
/*
  Package for the node identity and PHY register access block: register
  offsets, field positions, reset values and the carrier structs.
  Assumes a 32-bit plain register port with byte addresses.
*/
package nid_pkg;
  localparam logic [7:0] NID_OFF_NODE_IDENTITY = 8'he8;
  localparam logic [7:0] NID_OFF_PHY_ACCESS = 8'hec;
  localparam logic [7:0] NID_OFF_IRQ_STATUS = 8'hf4;
  localparam logic [7:0] NID_OFF_IRQ_MASK = 8'hf8;

  localparam int NID_VALID_BIT = 31;
  localparam int NID_ROOT_BIT = 30;
  localparam int NID_CPS_BIT = 27;
  localparam int NID_BUS_LSB = 6;
  localparam int NID_DONE_BIT = 31;
  localparam int NID_RADDR_LSB = 24;
  localparam int NID_RDATA_LSB = 16;
  localparam int NID_RDREQ_BIT = 15;
  localparam int NID_WRREQ_BIT = 14;
  localparam int NID_TADDR_LSB = 8;

  localparam logic [9:0] NID_BUS_INDEX_RST = 10'h3ff;
  localparam logic [5:0] NID_NODE_UNSET = 6'h3f;
  localparam logic [5:0] NID_NODE_LAST = 6'h3f;
  localparam logic [31:0] NID_ZERO32 = 32'h0000_0000;

  // irq status bits
  localparam int NID_IRQ_BUS_RESET = 0;
  localparam int NID_IRQ_NODE_LOADED = 1;
  localparam int NID_IRQ_PHY_DONE = 2;
  localparam int NID_IRQ_W = 3;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } nid_bus_req_s;

  typedef struct packed {
    logic valid;
    logic is_write;
    logic [3:0] index;
    logic [7:0] value;
  } nid_phy_req_s;

  typedef struct packed {
    logic valid;
    logic [3:0] index;
    logic [7:0] value;
  } nid_phy_rsp_s;
endpackage

// ### rtl/nid_regs.sv
/*
  Node identity and PHY register access registers of a link controller.
  Assumes the link-to-PHY protocol engine sits outside: it takes one
  request held until ready, reports bus reset, self-id completion and returned
  register transfers as same-clock pulses, and holds root and cable
  power status as same-clock levels.
*/
`timescale 1ns/1ns
// Overview of operation
// - node id is bus index over node index
// - valid cleared on bus reset, set on load
// - root bit sampled from phy on bus reset
// - cable power bit follows phy status
// - node identity reserved bits read zero
// - bus index writable, resets to all ones
// - node index loaded after self-id, read-only
// - read complete cleared when request set
// - returned transfer sets done, index, value
// - read request cleared once sent
// - write request cleared once sent
// - target index writable, resets zero
// - write value writable, resets zero
// - phy access reserved bits read zero
module nid_regs
  import nid_pkg::*;
(
  input wire logic sys_clk, // 10 MHz core clock
  input wire logic sys_rst, // async reset, active high
  input wire nid_bus_req_s bus_req, // register port request
  output logic [31:0] bus_rdata, // read data, cycle after read
  input wire logic phy_bus_reset, // bus reset detected pulse
  input wire logic phy_selfid_done, // node index ready pulse
  input wire logic [5:0] phy_node_index, // node index from phy
  input wire logic phy_is_root, // phy reports root, level
  input wire logic phy_cable_power, // cable power good, level
  input wire nid_phy_rsp_s phy_rsp, // returned register transfer
  input wire logic phy_req_ready, // engine accepts a request
  output nid_phy_req_s phy_req, // request to the engine
  output logic [15:0] node_id, // bus index and node index
  output logic node_id_valid, // node identifier valid
  output logic irq // level interrupt
);

  logic valid_r;
  logic root_r;
  logic cps_r;
  logic [9:0] bus_index_r;
  logic [5:0] node_index_r;
  logic done_r;
  logic [3:0] ret_index_r;
  logic [7:0] ret_value_r;
  logic rd_req_r;
  logic wr_req_r;
  logic [3:0] tgt_index_r;
  logic [7:0] wr_value_r;
  logic [NID_IRQ_W-1:0] irq_stat_r;
  logic [NID_IRQ_W-1:0] irq_mask_r;
  logic [NID_IRQ_W-1:0] irq_set;
  logic wr_node;
  logic wr_phy;
  logic wr_stat;
  logic wr_mask;
  logic req_sent;
  logic [31:0] rd_nxt;

  function automatic logic hit(input nid_bus_req_s r,
                               input logic [7:0] off);
    hit = r.wr && (r.addr == off);
  endfunction

  assign wr_node = hit(bus_req, NID_OFF_NODE_IDENTITY);
  assign wr_phy = hit(bus_req, NID_OFF_PHY_ACCESS);
  assign wr_stat = hit(bus_req, NID_OFF_IRQ_STATUS);
  assign wr_mask = hit(bus_req, NID_OFF_IRQ_MASK);
  // phy_req.valid is a register, so the engine takes it the cycle it
  // stands with ready high
  assign req_sent = phy_req.valid && phy_req_ready;

  // node identity state
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      valid_r <= 1'b0;
      node_index_r <= NID_NODE_UNSET;
    end
    else if (phy_selfid_done)
    begin
      valid_r <= 1'b1;
      node_index_r <= phy_node_index;
    end
    else if (phy_bus_reset)
      valid_r <= 1'b0;
  end

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      root_r <= 1'b0;
      cps_r <= 1'b0;
    end
    else
    begin
      // root sampled only while bus reset runs, then held
      if (phy_bus_reset)
        root_r <= phy_is_root;
      cps_r <= phy_cable_power;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      bus_index_r <= NID_BUS_INDEX_RST;
    else if (wr_node)
      bus_index_r <= bus_req.wdata[NID_BUS_LSB +: 10];
  end

  // phy access control fields
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      tgt_index_r <= 4'h0;
      wr_value_r <= 8'h00;
    end
    else if (wr_phy)
    begin
      tgt_index_r <= bus_req.wdata[NID_TADDR_LSB +: 4];
      wr_value_r <= bus_req.wdata[7:0];
    end
  end

  // request bits: writing one sets, hardware clears on send; a write of
  // zero leaves a pending request alone so software cannot cancel mid-way
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rd_req_r <= 1'b0;
      wr_req_r <= 1'b0;
    end
    else
    begin
      // a request written in the send cycle stays queued, not lost
      if (wr_phy && bus_req.wdata[NID_RDREQ_BIT])
        rd_req_r <= 1'b1;
      else if (req_sent && !phy_req.is_write)
        rd_req_r <= 1'b0;
      if (wr_phy && bus_req.wdata[NID_WRREQ_BIT])
        wr_req_r <= 1'b1;
      else if (req_sent && phy_req.is_write)
        wr_req_r <= 1'b0;
    end
  end

  // one request held at a time, read wins if software broke the pairing
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      phy_req <= '0;
    else if (req_sent)
      phy_req <= '0;
    else if (!phy_req.valid && (rd_req_r || wr_req_r) && !wr_phy)
    begin
      phy_req.valid <= 1'b1;
      phy_req.is_write <= !rd_req_r;
      phy_req.index <= tgt_index_r;
      phy_req.value <= wr_value_r;
    end
  end

  // returned transfer sets done; a fresh request clears it
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      done_r <= 1'b0;
      ret_index_r <= 4'h0;
      ret_value_r <= 8'h00;
    end
    else if (phy_rsp.valid)
    begin
      done_r <= 1'b1;
      ret_index_r <= phy_rsp.index;
      ret_value_r <= phy_rsp.value;
    end
    else if (wr_phy && (bus_req.wdata[NID_RDREQ_BIT] ||
                        bus_req.wdata[NID_WRREQ_BIT]))
      done_r <= 1'b0;
  end

  // interrupts: set wins over write-one-to-clear
  assign irq_set = {phy_rsp.valid, phy_selfid_done, phy_bus_reset};

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      irq_stat_r <= '0;
      irq_mask_r <= '0;
      irq <= 1'b0;
    end
    else
    begin
      irq_stat_r <= (irq_stat_r &
                     ~(wr_stat ? bus_req.wdata[NID_IRQ_W-1:0] : '0))
                    | irq_set;
      if (wr_mask)
        irq_mask_r <= bus_req.wdata[NID_IRQ_W-1:0];
      irq <= |(irq_stat_r & irq_mask_r);
    end
  end

  // read path
  always_comb
  begin
    rd_nxt = NID_ZERO32;
    if (bus_req.addr == NID_OFF_NODE_IDENTITY)
    begin
      rd_nxt[NID_VALID_BIT] = valid_r;
      rd_nxt[NID_ROOT_BIT] = root_r;
      rd_nxt[NID_CPS_BIT] = cps_r;
      rd_nxt[15:0] = {bus_index_r, node_index_r};
    end
    else if (bus_req.addr == NID_OFF_PHY_ACCESS)
    begin
      rd_nxt[NID_DONE_BIT] = done_r;
      rd_nxt[NID_RADDR_LSB +: 4] = ret_index_r;
      rd_nxt[NID_RDATA_LSB +: 8] = ret_value_r;
      rd_nxt[NID_RDREQ_BIT] = rd_req_r;
      rd_nxt[NID_WRREQ_BIT] = wr_req_r;
      rd_nxt[NID_TADDR_LSB +: 4] = tgt_index_r;
      rd_nxt[7:0] = wr_value_r;
    end
    else if (bus_req.addr == NID_OFF_IRQ_STATUS)
      rd_nxt[NID_IRQ_W-1:0] = irq_stat_r;
    else if (bus_req.addr == NID_OFF_IRQ_MASK)
      rd_nxt[NID_IRQ_W-1:0] = irq_mask_r;
  end

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      bus_rdata <= NID_ZERO32;
    else if (bus_req.rd)
      bus_rdata <= rd_nxt;
    else
      bus_rdata <= NID_ZERO32;
  end

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      node_id <= {NID_BUS_INDEX_RST, NID_NODE_UNSET};
      node_id_valid <= 1'b0;
    end
    else
    begin
      node_id <= {bus_index_r, node_index_r};
      node_id_valid <= valid_r;
    end
  end

  a_valid_clear: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    phy_bus_reset && !phy_selfid_done |=> !valid_r)
    else $error("valid not cleared by bus reset");

  a_node_load: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    phy_selfid_done |=> valid_r && node_index_r == $past(phy_node_index))
    else $error("node index not loaded");

  a_cps_follow: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    ##1 cps_r == $past(phy_cable_power))
    else $error("cable power bit wrong");

  a_done_set: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    phy_rsp.valid |=> done_r && ret_value_r == $past(phy_rsp.value))
    else $error("returned transfer not stored");

  a_done_clear: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    wr_phy && bus_req.wdata[NID_RDREQ_BIT] && !phy_rsp.valid
    |=> !done_r)
    else $error("done not cleared on request");

  a_rd_clear: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    req_sent && !phy_req.is_write &&
    !(wr_phy && bus_req.wdata[NID_RDREQ_BIT]) |=> !rd_req_r)
    else $error("read request not cleared");

  a_wr_clear: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    req_sent && phy_req.is_write &&
    !(wr_phy && bus_req.wdata[NID_WRREQ_BIT]) |=> !wr_req_r)
    else $error("write request not cleared");

  a_one_outstanding: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    phy_req.valid && !phy_req_ready |=> $stable(phy_req))
    else $error("request changed while pending");

  a_reserved_zero: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    bus_req.rd && bus_req.addr == NID_OFF_NODE_IDENTITY
    |=> bus_rdata[29:28] == 2'b00 && bus_rdata[26:16] == 11'h000)
    else $error("reserved bits not zero");

  a_bus_index_rst: assert property (
    @(posedge sys_clk) $fell(sys_rst) |-> bus_index_r == NID_BUS_INDEX_RST)
    else $error("bus index reset wrong");

  a_root_sample: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    phy_bus_reset |=> root_r == $past(phy_is_root))
    else $error("root bit not sampled");

  a_bus_index_wr: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    wr_node |=> bus_index_r == $past(bus_req.wdata[NID_BUS_LSB +: 10]))
    else $error("bus index not written");

  a_phy_fields: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    wr_phy |=> tgt_index_r == $past(bus_req.wdata[NID_TADDR_LSB +: 4]) &&
    wr_value_r == $past(bus_req.wdata[7:0]))
    else $error("phy access fields not written");

  a_phy_reserved: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    bus_req.rd && bus_req.addr == NID_OFF_PHY_ACCESS
    |=> bus_rdata[30:28] == 3'b000 && bus_rdata[13:12] == 2'b00)
    else $error("phy access reserved bits not zero");

  a_node_id_out: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    ##1 node_id == {$past(bus_index_r), $past(node_index_r)})
    else $error("node id output wrong");

  a_req_drop: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    req_sent |=> !phy_req.valid)
    else $error("request held after send");

  a_irq_level: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    ##1 irq == |($past(irq_stat_r) & $past(irq_mask_r)))
    else $error("interrupt level wrong");

  a_irq_set: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    phy_bus_reset |=> irq_stat_r[NID_IRQ_BUS_RESET])
    else $error("bus reset event not latched");

  c_phy_read: cover property (
    @(posedge sys_clk) disable iff (sys_rst)
    req_sent && !phy_req.is_write ##[1:20] phy_rsp.valid);
  c_phy_write: cover property (
    @(posedge sys_clk) disable iff (sys_rst)
    req_sent && phy_req.is_write);
  c_reset_load: cover property (
    @(posedge sys_clk) disable iff (sys_rst)
    phy_bus_reset ##[1:50] phy_selfid_done);
  c_irq: cover property (
    @(posedge sys_clk) disable iff (sys_rst) $rose(irq));
  c_queued_req: cover property (
    @(posedge sys_clk) disable iff (sys_rst)
    req_sent && wr_phy && bus_req.wdata[NID_RDREQ_BIT]);
endmodule

// ### testbench/nid_phy_model.sv
/*
  Behavioural model of the link-to-PHY engine and PHY register file.
  Assumes the nid_regs request port: valid level held until ready.
*/
`timescale 1ns/1ns
module nid_phy_model
  import nid_pkg::*;
(
  input wire logic sys_clk, // core clock
  input wire logic sys_rst, // async reset, active high
  input wire nid_phy_req_s phy_req, // request from the block
  input wire logic slow, // stretch the accept delay
  output logic phy_req_ready, // request taken
  output nid_phy_rsp_s phy_rsp // returned register transfer
);
  logic [7:0] mem [16];
  logic [2:0] wait_r;

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      phy_req_ready <= 1'b0;
      wait_r <= 3'h0;
      phy_rsp <= '0;
      for (int i = 0; i < 16; i++)
        mem[i] <= 8'h30 + 8'(i);
    end
    else
    begin
      // released response lines flip rather than hold
      phy_rsp <= '{1'b0, ~phy_rsp.index, ~phy_rsp.value};
      if (phy_req.valid && phy_req_ready)
      begin
        phy_req_ready <= 1'b0;
        wait_r <= 3'h0;
        if (phy_req.is_write)
          mem[phy_req.index] <= phy_req.value;
        else
          phy_rsp <= '{1'b1, phy_req.index, mem[phy_req.index]};
      end
      else if (phy_req.valid)
      begin
        // ready only once a request is pending: one at a time
        if (wait_r == (slow ? 3'h5 : 3'h0))
          phy_req_ready <= 1'b1;
        else
          wait_r <= wait_r + 3'h1;
      end
    end
  end
endmodule

// ### testbench/nid_regs_tb_top.sv
/*
  Self-checking bench for nid_regs: register port, node events, PHY
  register transfers, interrupts. Assumes nid_phy_model at the far side.
*/
`timescale 1ns/1ns
module nid_regs_tb_top
  import nid_pkg::*;
;
  logic sys_clk, sys_rst, phy_bus_reset, phy_selfid_done, phy_is_root;
  logic phy_cable_power, phy_req_ready, node_id_valid, irq, slow;
  logic [5:0] phy_node_index;
  logic [31:0] bus_rdata, d;
  logic [15:0] node_id;
  nid_bus_req_s bus_req;
  nid_phy_rsp_s phy_rsp;
  nid_phy_req_s phy_req;
  int err_count, checked;

  nid_regs dut_u (.sys_clk(sys_clk), .sys_rst(sys_rst), .bus_req(bus_req),
    .bus_rdata(bus_rdata), .phy_bus_reset(phy_bus_reset),
    .phy_selfid_done(phy_selfid_done), .phy_node_index(phy_node_index),
    .phy_is_root(phy_is_root), .phy_cable_power(phy_cable_power),
    .phy_rsp(phy_rsp), .phy_req_ready(phy_req_ready), .phy_req(phy_req),
    .node_id(node_id), .node_id_valid(node_id_valid), .irq(irq));

  nid_phy_model phy_u (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .phy_req(phy_req), .slow(slow), .phy_req_ready(phy_req_ready),
    .phy_rsp(phy_rsp));

  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic bus_wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    bus_req <= '{a, v, 1'b1, 1'b0};
    @(posedge sys_clk);
    bus_req <= '0;
  endtask

  task automatic bus_rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge sys_clk);
    bus_req <= '{a, 32'h0000_0000, 1'b0, 1'b1};
    @(posedge sys_clk);
    bus_req <= '0;
    #1 v = bus_rdata;
  endtask

  task automatic pulse(input logic br, input logic sd, input logic [5:0] n);
    @(posedge sys_clk);
    phy_bus_reset <= br;
    phy_selfid_done <= sd;
    phy_node_index <= n;
    @(posedge sys_clk);
    phy_bus_reset <= 1'b0;
    phy_selfid_done <= 1'b0;
  endtask

  // bounded poll of the access register until masked bits match
  task automatic poll(input logic [31:0] m, input logic [31:0] v);
    for (int i = 0; i < 40; i++)
    begin
      bus_rd(NID_OFF_PHY_ACCESS, d);
      if ((d & m) === v)
        break;
    end
  endtask

  task automatic t_reset();
    bus_rd(NID_OFF_NODE_IDENTITY, d);
    check(d, 32'h0000_ffff);
    check({16'h0000, node_id}, 32'h0000_ffff);
    bus_rd(NID_OFF_PHY_ACCESS, d);
    check(d, 32'h0000_0000);
    bus_rd(8'hf0, d);
    check(d, 32'h0000_0000);
  endtask

  task automatic t_node();
    phy_is_root <= 1'b1;
    phy_cable_power <= 1'b1;
    pulse(1'b1, 1'b0, 6'h00);
    bus_rd(NID_OFF_NODE_IDENTITY, d);
    check(d, 32'h4800_ffff);
    pulse(1'b0, 1'b1, 6'h05);
    bus_wr(NID_OFF_NODE_IDENTITY, 32'hffff_5555);
    bus_rd(NID_OFF_NODE_IDENTITY, d);
    check(d, 32'hc800_5545);
    repeat (2) @(posedge sys_clk);
    #1 check({15'h0000, node_id_valid, node_id}, 32'h0001_5545);
    phy_is_root <= 1'b0;
    phy_cable_power <= 1'b0;
    pulse(1'b1, 1'b0, 6'h00);
    bus_rd(NID_OFF_NODE_IDENTITY, d);
    check(d, 32'h0000_5545);
  endtask

  task automatic t_phy();
    slow <= 1'b1;
    bus_wr(NID_OFF_PHY_ACCESS, 32'hffff_8300);
    bus_rd(NID_OFF_PHY_ACCESS, d);
    check(d, 32'h0000_8300);
    poll(32'h8000_8000, 32'h8000_0000);
    check(d, 32'h8333_0300);
    bus_wr(NID_OFF_PHY_ACCESS, 32'h0000_42a5);
    bus_rd(NID_OFF_PHY_ACCESS, d);
    check(d, 32'h0333_42a5);
    poll(32'h0000_4000, 32'h0000_0000);
    check(d, 32'h0333_02a5);
    slow <= 1'b0;
    bus_wr(NID_OFF_PHY_ACCESS, 32'h0000_8200);
    poll(32'h8000_8000, 32'h8000_0000);
    check(d, 32'h82a5_0200);
  endtask

  task automatic t_irq();
    bus_rd(NID_OFF_IRQ_STATUS, d);
    check(d, 32'h0000_0007);
    check({31'h0, irq}, 32'h0000_0000);
    bus_wr(NID_OFF_IRQ_MASK, 32'h0000_0002);
    @(posedge sys_clk);
    #1 check({31'h0, irq}, 32'h0000_0001);
    bus_wr(NID_OFF_IRQ_STATUS, 32'h0000_0002);
    @(posedge sys_clk);
    #1 check({31'h0, irq}, 32'h0000_0000);
    bus_rd(NID_OFF_IRQ_STATUS, d);
    check(d, 32'h0000_0005);
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial
  begin
    #2_000_000;
    err_count++;
    test_done();
  end

  initial
  begin
    sys_rst = 1'b1;
    bus_req = '0;
    phy_bus_reset = 1'b0;
    phy_selfid_done = 1'b0;
    phy_node_index = 6'h00;
    phy_is_root = 1'b0;
    phy_cable_power = 1'b0;
    slow = 1'b0;
    err_count = 0;
    checked = 0;
    repeat (12) @(posedge sys_clk);
    sys_rst <= 1'b0;
    t_reset();
    t_node();
    t_phy();
    t_irq();
    test_done();
  end
endmodule
